//--- sync_master_serial_receiver.v
// Purpose: Receive path of a clocked serial port in master mode
// Assumes: Avalon-MM slave with waitrequest, 200 MHz clk_sys
// Notes:   Shift clock is divided from clk_sys and idles low
// Operation
// - Receiver runs when single or continuous enable is set with the port enabled in clocked master mode.
// - Serial data is sampled on the falling edge of the generated clock.
// - Single enable receives one word, then hardware clears it.
// - Continuous enable receives words back to back until cleared.
// - With both enables set, continuous reception wins.
// - Nine-bit enable gives 9-bit words; ninth bit lands in status register.
// - Completion sets the receive flag; request only when its enable is set.
// - Reading the data register returns the 8-bit received word.
// - Clearing continuous enable clears the receive error state.
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_consts.vh"

module sync_master_serial_receiver (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [5:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [3:0]  byteenable,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  input  wire        rxData,
  output reg         shiftClk,
  output wire        shiftClkEn,
  output wire        irqRequest
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_HIGH = 3'b010;
  localparam [2:0] ST_LOW  = 3'b100;

  reg  [7:0]  intCtrl;
  reg  [7:0]  periphEn;
  reg  [7:0]  periphPrio;
  reg  [7:0]  rxCtrl;
  reg  [7:0]  txCtrl;
  reg  [7:0]  rateCtrl;
  reg  [7:0]  divHigh;
  reg  [7:0]  divLow;
  reg  [7:0]  rxWord;
  reg         ninthBit;
  reg         wordReady;
  reg         overrunErr;
  reg         ack;
  reg  [2:0]  state;
  reg  [15:0] halfCount;
  reg  [3:0]  bitCount;
  reg  [8:0]  shiftReg;
  wire        rxDataSync;

  pin_sync3 u_rx_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (rxData),
    .pinOut  (rxDataSync)
  );

  // Bus access decode; writes land only on the low byte lane
  wire        busTake   = (read | write) & ~ack;
  wire        wrStrobe  = write & ack & byteenable[0];
  wire        rdStrobe  = read & ack;
  wire [7:0]  wrByte    = writedata[7:0];
  wire        wrRxCtrl  = wrStrobe && (address == `OFS_RECEIVE_STATUS_CTRL);
  wire        popData   = rdStrobe && (address == `OFS_RECEIVE_DATA_WORD);

  assign waitrequest = (read | write) & ~ack;

  wire portEnable  = rxCtrl[`BIT_SERIAL_PORT_EN];
  wire clockedMode = txCtrl[`BIT_CLOCKED_MODE_SEL];
  wire masterClock = txCtrl[`BIT_CLOCK_SOURCE_SEL];
  wire contEnable  = rxCtrl[`BIT_CONT_RX_EN];
  wire singleEn    = rxCtrl[`BIT_SINGLE_RX_EN];
  wire nineBits    = rxCtrl[`BIT_NINE_BIT_EN];
  wire wideDiv     = rateCtrl[`BIT_WIDE_DIVISOR_SEL];
  wire masterReady = portEnable & clockedMode & masterClock;
  wire rxActive    = masterReady & (contEnable | singleEn);
  wire [15:0] divisor  = wideDiv ? {divHigh, divLow} : {8'h00, divLow};
  wire [3:0]  lastBit  = nineBits ? 4'h8 : 4'h7;
  wire        halfDone = (halfCount == divisor);
  wire [8:0]  nextShift = {rxDataSync, shiftReg[8:1]};
  wire        fallEdge  = (state == ST_HIGH) && rxActive && halfDone;
  wire        wordDone  = fallEdge && (bitCount == lastBit);

  assign shiftClkEn = masterReady;

  // Request raised only with all three enables; priority has no effect here
  assign irqRequest = wordReady & periphEn[`BIT_RECEIVE_IRQ]
                    & intCtrl[`BIT_GLOBAL_IRQ_EN]
                    & intCtrl[`BIT_PERIPH_IRQ_EN];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= busTake;
    end
  end

  // Software registers
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      intCtrl    <= `RST_BYTE;
      periphEn   <= `RST_BYTE;
      periphPrio <= `RST_BYTE;
      rxCtrl     <= `RST_BYTE;
      txCtrl     <= `RST_BYTE;
      rateCtrl   <= `RST_BYTE;
      divHigh    <= `RST_DIVISOR;
      divLow     <= `RST_DIVISOR;
    end else begin
      if (wrStrobe && (address == `OFS_INTERRUPT_CONTROL)) begin
        intCtrl <= wrByte;
      end else if (wrStrobe && (address == `OFS_PERIPH_ENABLES_ONE)) begin
        periphEn <= wrByte;
      end else if (wrStrobe && (address == `OFS_PERIPH_PRIOS_ONE)) begin
        periphPrio <= wrByte;
      end else if (wrRxCtrl) begin
        // Status bits are hardware owned and not stored here
        rxCtrl <= {wrByte[7:3], 3'b000};
      end else if (wrStrobe && (address == `OFS_TRANSMIT_STATUS_CTRL)) begin
        txCtrl <= {wrByte[7:2], 2'b00};
      end else if (wrStrobe && (address == `OFS_RATE_GEN_CONTROL)) begin
        rateCtrl <= {4'h0, wrByte[3], 3'b000};
      end else if (wrStrobe && (address == `OFS_RATE_DIVISOR_HIGH)) begin
        divHigh <= wrByte;
      end else if (wrStrobe && (address == `OFS_RATE_DIVISOR_LOW)) begin
        divLow <= wrByte;
      end
      // Single word done: drop the single enable unless software writes now
      if (wordDone && !contEnable && !wrRxCtrl) begin
        rxCtrl[`BIT_SINGLE_RX_EN] <= 1'b0;
      end
    end
  end

  // Shift clock generator and bit sampler
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      shiftClk  <= 1'b0;
      halfCount <= 16'h0000;
      bitCount  <= 4'h0;
      shiftReg  <= 9'h000;
    end else begin
      case (state)
        ST_IDLE: begin
          shiftClk  <= 1'b0;
          halfCount <= 16'h0000;
          bitCount  <= 4'h0;
          if (rxActive) begin
            shiftClk <= 1'b1;
            state    <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (!rxActive) begin
            shiftClk <= 1'b0;
            state    <= ST_IDLE;
          end else if (halfDone) begin
            halfCount <= 16'h0000;
            shiftClk  <= 1'b0;
            shiftReg  <= nextShift;
            bitCount  <= wordDone ? 4'h0 : bitCount + 4'h1;
            state     <= ST_LOW;
          end else begin
            halfCount <= halfCount + 16'h0001;
          end
        end
        ST_LOW: begin
          if (!rxActive) begin
            // Single enable cleared after its word lands here too
            shiftClk <= 1'b0;
            state    <= ST_IDLE;
          end else if (halfDone) begin
            // Continuous enable keeps words back to back
            halfCount <= 16'h0000;
            shiftClk  <= 1'b1;
            state     <= ST_HIGH;
          end else begin
            halfCount <= halfCount + 16'h0001;
          end
        end
        default: begin
          shiftClk <= 1'b0;
          state    <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive holding register, flag and overrun
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxWord     <= 8'h00;
      ninthBit   <= 1'b0;
      wordReady  <= 1'b0;
      overrunErr <= 1'b0;
    end else begin
      if (wordDone && (!wordReady || popData)) begin
        rxWord    <= nineBits ? nextShift[7:0] : nextShift[8:1];
        ninthBit  <= nineBits ? nextShift[8] : 1'b0;
        wordReady <= 1'b1;
      end else if (popData) begin
        wordReady <= 1'b0;
      end
      if (wordDone && wordReady && !popData) begin
        overrunErr <= 1'b1;
      end else if (wrRxCtrl && contEnable && !wrByte[`BIT_CONT_RX_EN]) begin
        overrunErr <= 1'b0;
      end
    end
  end

  // Read data, registered at the acknowledge edge
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
    end else if (busTake && read) begin
      if (address == `OFS_INTERRUPT_CONTROL) begin
        readdata <= {24'h000000, intCtrl};
      end else if (address == `OFS_PERIPH_FLAGS_ONE) begin
        readdata <= {24'h000000, 2'b00, wordReady, 5'b00000};
      end else if (address == `OFS_PERIPH_ENABLES_ONE) begin
        readdata <= {24'h000000, periphEn};
      end else if (address == `OFS_PERIPH_PRIOS_ONE) begin
        readdata <= {24'h000000, periphPrio};
      end else if (address == `OFS_RECEIVE_STATUS_CTRL) begin
        // Framing error cannot occur in clocked mode, reads zero
        readdata <= {24'h000000, rxCtrl[7:3], 1'b0, overrunErr, ninthBit};
      end else if (address == `OFS_RECEIVE_DATA_WORD) begin
        readdata <= {24'h000000, rxWord};
      end else if (address == `OFS_TRANSMIT_STATUS_CTRL) begin
        readdata <= {24'h000000, txCtrl[7:2], 1'b1, 1'b0};
      end else if (address == `OFS_RATE_GEN_CONTROL) begin
        readdata <= {24'h000000, 1'b0, (state == ST_IDLE), 2'b00,
                     rateCtrl[`BIT_WIDE_DIVISOR_SEL], 3'b000};
      end else if (address == `OFS_RATE_DIVISOR_HIGH) begin
        readdata <= {24'h000000, divHigh};
      end else if (address == `OFS_RATE_DIVISOR_LOW) begin
        readdata <= {24'h000000, divLow};
      end else begin
        readdata <= 32'h00000000;
      end
    end
  end

endmodule // sync_master_serial_receiver

`default_nettype wire

//--- sync_rx_consts.vh
// Purpose: Offsets, field positions and reset values of the receiver
// Assumes: Avalon-MM byte addresses, one register per aligned word
// Notes:   Registers are 8 bits wide in the low byte lane
`ifndef SYNC_RX_CONSTS_VH
`define SYNC_RX_CONSTS_VH

`define OFS_INTERRUPT_CONTROL    6'h00
`define OFS_PERIPH_FLAGS_ONE     6'h04
`define OFS_PERIPH_ENABLES_ONE   6'h08
`define OFS_PERIPH_PRIOS_ONE     6'h0C
`define OFS_RECEIVE_STATUS_CTRL  6'h10
`define OFS_RECEIVE_DATA_WORD    6'h14
`define OFS_TRANSMIT_STATUS_CTRL 6'h18
`define OFS_RATE_GEN_CONTROL     6'h1C
`define OFS_RATE_DIVISOR_HIGH    6'h20
`define OFS_RATE_DIVISOR_LOW     6'h24

// interrupt_control
`define BIT_GLOBAL_IRQ_EN        7
`define BIT_PERIPH_IRQ_EN        6
// peripheral_flags_one / peripheral_enables_one
`define BIT_RECEIVE_IRQ          5
// receive_status_control
`define BIT_SERIAL_PORT_EN       7
`define BIT_NINE_BIT_EN          6
`define BIT_SINGLE_RX_EN         5
`define BIT_CONT_RX_EN           4
`define BIT_ADDRESS_DET_EN       3
`define BIT_FRAMING_ERR          2
`define BIT_OVERRUN_ERR          1
`define BIT_NINTH_BIT            0
// transmit_status_control
`define BIT_CLOCK_SOURCE_SEL     7
`define BIT_CLOCKED_MODE_SEL     4
`define BIT_SHIFT_EMPTY          1
// rate_generator_control
`define BIT_RECEIVE_IDLE         6
`define BIT_WIDE_DIVISOR_SEL     3

`define RST_BYTE                 8'h00
`define RST_DIVISOR              8'h00

`endif

//--- pin_sync3.v
// Purpose: Three-stage synchroniser with agreement filter for a pin
// Assumes: Input is asynchronous to clk_sys
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire pinIn,
  output reg  pinOut
);

  reg stageOne;
  reg stageTwo;
  reg stageThree;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stageOne   <= 1'b0;
      stageTwo   <= 1'b0;
      stageThree <= 1'b0;
      pinOut     <= 1'b0;
    end else begin
      stageOne   <= pinIn;
      stageTwo   <= stageOne;
      stageThree <= stageTwo;
      if (stageTwo == stageThree) begin
        pinOut <= stageThree;
      end
    end
  end

endmodule // pin_sync3

`default_nettype wire

//--- sync_rx_properties.sv
// Purpose: Port properties of the clocked serial receiver
// Assumes: Bench sets divisor 7, so a shift clock half is 8 cycles
// Notes:   Sees the receiver's ports only
`timescale 1ns/1ps
`default_nettype none
module sync_rx_properties (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        rxData,
  input wire logic        shiftClk,
  input wire logic        shiftClkEn,
  input wire logic        irqRequest
);
  logic rdDone;
  assign rdDone = read && !waitrequest;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence highHalf; shiftClk [*8]; endsequence
  sequence lowHalf; !shiftClk [*8]; endsequence
  wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus wait not one cycle");
  upper_zero_a: assert property (rdDone |-> readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  unmapped_zero_a: assert property (rdDone && address > 6'h24 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  high_half_a: assert property ($rose(shiftClk) |-> highHalf ##1 !shiftClk)
    else $error("shift clock high half wrong");
  low_half_a: assert property ($fell(shiftClk) |-> lowHalf)
    else $error("shift clock low half short");
  clk_parked_a: assert property (!shiftClkEn && !$past(shiftClkEn) |-> !shiftClk)
    else $error("shift clock runs while disabled");
  irq_drop_a: assert property (rdDone && address == 6'h14 |=> !irqRequest)
    else $error("request stays after data read");
  irq_after_word_a: assert property ($rose(irqRequest) |-> !shiftClk &&
    ($past(shiftClk, 1) || $past(shiftClk, 2) || $past(shiftClk, 3)))
    else $error("request without a completed word");
endmodule // sync_rx_properties
bind sync_master_serial_receiver sync_rx_properties props (.clk_sys(clk_sys),
  .rst_n(rst_n), .address(address), .read(read), .write(write), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .rxData(rxData), .shiftClk(shiftClk), .shiftClkEn(shiftClkEn), .irqRequest(irqRequest));
`default_nettype wire

//--- serial_slave_model.sv
// Purpose: Serial slave that shifts words into the receiver
// Assumes: Data changes after each rising shift clock edge
// Notes:   Pin turns to the inverse once its hold time is over
`timescale 1ns/1ps
`default_nettype none
module serial_slave_model (
  input  wire logic shiftClk,
  input  wire logic nineBit,
  output var  logic rxData
);
  logic [8:0] words[$];
  logic [8:0] cur;
  int         idx = 0;
  initial rxData = 1'b0;
  task automatic push(input logic [8:0] w);
    words.push_back(w);
  endtask
  always @(posedge shiftClk) begin
    if (idx == 0)
      cur = (words.size() != 0) ? words.pop_front() : 9'($urandom);
    rxData <= cur[idx];
    idx = (idx == (nineBit ? 8 : 7)) ? 0 : idx + 1;
  end
  // No stale bit for a late sampler to rely on
  always @(negedge shiftClk) rxData <= #20 ~rxData;
endmodule // serial_slave_model
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the clocked serial receiver
// Assumes: Divisor 7 gives an 80 ns shift clock, 16 clk_sys cycles per period
// Notes:   Read results are noted in a queue, checked at the answer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic        nineBit = 1'b0;
  wire  [31:0] readdata;
  wire         waitrequest, rxData, shiftClk, shiftClkEn, irqRequest;
  logic [63:0] expQ[$];
  logic [31:0] lastData = 32'h0;
  logic [8:0]  w0, w1;
  int          bad_count = 0;
  int          tests_run = 0;
  always #2.5 clk_sys = ~clk_sys;
  sync_master_serial_receiver dut (.clk_sys(clk_sys), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .rxData(rxData),
    .shiftClk(shiftClk), .shiftClkEn(shiftClkEn), .irqRequest(irqRequest));
  serial_slave_model slave (.shiftClk(shiftClk), .nineBit(nineBit), .rxData(rxData));
  task automatic cmp(input logic [31:0] got, input logic [63:0] note);
    tests_run++;
    if ((got & note[63:32]) !== note[31:0]) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, note[31:0]);
    end
  endtask
  // Read data stands at the edge where waitrequest is seen low
  always @(posedge clk_sys)
    if (read && !waitrequest && expQ.size() != 0) begin
      lastData = readdata;
      if (expQ[0][63:32] != 32'h0) cmp(readdata, expQ[0]);
      void'(expQ.pop_front());
    end
  task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d, m);
    if (!wr) expQ.push_back({m, d});
    address <= a;
    writedata <= d;
    byteenable <= m[3:0];
    read <= !wr;
    write <= wr;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) @(posedge clk_sys);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic waitBit(input logic [5:0] a, input int b);
    lastData = 32'h0;
    while (lastData[b] !== 1'b1) bus(0, a, 0, 0);
  endtask
  task automatic test_done();
    $display("mismatches %0d, checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("mismatch at %0t: timeout", $time);
    test_done();
  end
  initial begin
    void'($urandom(32'h2EDF1CD3));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus(1, 6'h24, 8'h55, 0);
    bus(1, 6'h2C, 8'hFF, 1);
    for (int a = 0; a < 64; a += 4)
      bus(0, 6'(a), (a == 24) ? 2 : (a == 28) ? 'h40 : 0, '1);
    bus(1, 6'h20, 8'h3C, 1);
    bus(1, 6'h24, 8'h07, 1);
    bus(1, 6'h18, 8'h90, 1);
    bus(1, 6'h10, 8'h80, 1);
    bus(1, 6'h08, 8'h20, 1);
    bus(1, 6'h00, 8'hC0, 1);
    w0 = 9'($urandom);
    slave.push(w0);
    bus(1, 6'h10, 8'hA0, 1);
    waitBit(6'h04, 5);
    cmp({31'h0, irqRequest}, {32'h1, 32'h1});
    bus(0, 6'h10, 8'h80, 8'hFF);
    bus(0, 6'h14, w0[7:0], '1);
    bus(0, 6'h04, 0, 8'h20);
    bus(0, 6'h1C, 8'h40, 8'h40);
    nineBit <= 1'b1;
    bus(1, 6'h08, 8'h00, 1);
    w0 = 9'($urandom);
    w1 = 9'($urandom);
    slave.push(w0);
    slave.push(w1);
    bus(1, 6'h10, 8'hF0, 1);
    waitBit(6'h04, 5);
    cmp({31'h0, irqRequest}, {32'h1, 32'h0});
    bus(0, 6'h10, {7'h78, w0[8]}, 8'hFF);
    bus(0, 6'h14, w0[7:0], '1);
    waitBit(6'h10, 1);
    bus(0, 6'h14, w1[7:0], '1);
    // Stop in a low half so no high half is cut short
    @(negedge shiftClk);
    @(posedge clk_sys);
    bus(1, 6'h10, 8'hC0, 1);
    bus(0, 6'h10, 8'hC0, 8'hFE);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
